// ==== core/nacf_params.svh ====
// constants for the persistent map access block: offsets, fields, codes
// assumes nothing; included by nacf_map_ram, nacf_top and the testbench
`ifndef NACF_PARAMS_SVH
`define NACF_PARAMS_SVH

// =====================================================================
// register addresses
`define NACF_CSR_ADDR 16'h8000
`define NACF_MAP_BASE 16'h8007
`define NACF_MAP_BYTES 256

// =====================================================================
// customer writeable area, as map indices
`define NACF_CUST_FIRST 16'h0077
`define NACF_CUST_LAST 16'h00A6

// =====================================================================
// control/status field positions
`define NACF_VEND_HI 15
`define NACF_VEND_LO 9
`define NACF_CMD_BIT 5
`define NACF_EXT_HI 1
`define NACF_EXT_LO 0

// =====================================================================
// codes and reset values
`define NACF_ST_IDLE 2'h0
`define NACF_ST_OK 2'h1
`define NACF_ST_BUSY 2'h2
`define NACF_ST_FAIL 2'h3
`define NACF_EXT_ALL 2'h3
`define NACF_CMD_LOAD 1'h0
`define NACF_CMD_COMMIT 1'h1
`define NACF_VEND_RESET 7'h00

`endif

// ==== core/nacf_pkg.sv ====
// types shared by the persistent map access block
// assumes nacf_params.svh is on the include path
package nacf_pkg;

   // ==================================================================
   // access state machine
   typedef enum logic [1:0]
   {
      NACF_IDLE,
      NACF_PENDING,
      NACF_IN_PROGRESS,
      NACF_COMPLETE
   } nacf_state_t;

   // ==================================================================
   // management register access, one strobe per frame
   typedef struct packed
   {
      logic write;
      logic read;
      logic [15:0] addr;
      logic [15:0] wdata;
   } nacf_mgmt_req_t;

   // ==================================================================
   // persistent storage byte transfer
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } nacf_store_req_t;

   typedef struct packed
   {
      logic ack;
      logic err;
      logic [7:0] rdata;
   } nacf_store_rsp_t;

endpackage : nacf_pkg

// ==== core/nacf_map_ram.sv ====
// volatile copy of the register map, one byte per entry
// assumes nothing; a write from both ports in one cycle goes to the engine port
`timescale 1ns/1ps
`include "nacf_params.svh"

module nacf_map_ram #(
   parameter int DEPTH = `NACF_MAP_BYTES,
   parameter int AW = 8
) (
   // clock
   input wire logic ref_clk,
   // host port
   input wire logic host_we,
   input wire logic [AW-1:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   // transfer engine port
   input wire logic eng_we,
   input wire logic [AW-1:0] eng_addr,
   input wire logic [7:0] eng_wdata,
   output logic [7:0] eng_rdata
);

   logic [7:0] mem [DEPTH];

   // engine wins a collision: a reload must not be half overwritten
   wire wr_en = eng_we | host_we;
   wire [AW-1:0] wr_addr = eng_we ? eng_addr : host_addr;
   wire [7:0] wr_data = eng_we ? eng_wdata : host_wdata;

   assign host_rdata = mem[host_addr];
   assign eng_rdata = mem[eng_addr];

   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

endmodule : nacf_map_ram

// ==== core/nacf_store_arb.sv ====
// grants the shared persistent storage to one subsystem at a time
// assumes each requester holds its request until it is done
`timescale 1ns/1ps

module nacf_store_arb (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // optical monitor side
   input wire logic mon_req,
   output logic mon_gnt,
   // map access side
   input wire logic map_req,
   output logic map_gnt
);

   logic mon_gnt_reg;
   logic map_gnt_reg;

   // an owner keeps the resource until it drops its request
   wire mon_gnt_next = mon_gnt_reg ? mon_req :
                       (!map_gnt_reg & mon_req);
   wire map_gnt_next = map_gnt_reg ? map_req :
                       (!mon_gnt_reg & !mon_req & map_req);

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         mon_gnt_reg <= 1'b0;
         map_gnt_reg <= 1'b0;
      end
      else
      begin
         mon_gnt_reg <= mon_gnt_next;
         map_gnt_reg <= map_gnt_next;
      end
   end

   assign mon_gnt = mon_gnt_reg;
   assign map_gnt = map_gnt_reg;

   chk_single_owner: assert property (
      @(posedge ref_clk) disable iff (reset)
      !(mon_gnt_reg && map_gnt_reg))
      else $error("storage granted to both subsystems");

endmodule : nacf_store_arb

// ==== core/nacf_top.sv ====
// persistent map access: control/status register, access state
// machine, byte transfer engine and the volatile register map
// assumes a management frame decoder on ref_clk giving one-cycle
// read/write strobes, and storage and monitor logic on ref_clk too
`timescale 1ns/1ps
`include "nacf_params.svh"

module nacf_top
   import nacf_pkg::*;
#(
   parameter int MAP_BYTES = `NACF_MAP_BYTES,
   parameter int AW = $clog2(MAP_BYTES),
   parameter bit AUTO_LOAD = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // management register access
   input wire nacf_pkg::nacf_mgmt_req_t mgmt_req,
   output logic [15:0] mgmt_rdata,
   // persistent storage
   output nacf_pkg::nacf_store_req_t store_req,
   input wire nacf_pkg::nacf_store_rsp_t store_rsp,
   // optical monitor sharing the storage
   input wire logic mon_req,
   output logic mon_gnt
);
   import nacf_pkg::*;

   // ==================================================================
   // state
   nacf_state_t state_reg;
   nacf_state_t state_next;
   logic cmd_reg;
   logic [1:0] ext_reg;
   logic [6:0] vend_reg;
   logic fail_reg;
   logic [AW-1:0] idx_reg;
   nacf_store_req_t req_reg;
   nacf_store_req_t req_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   // ==================================================================
   // address decode
   wire csr_hit = mgmt_req.addr == `NACF_CSR_ADDR;
   wire [15:0] map_off = mgmt_req.addr - `NACF_MAP_BASE;
   wire map_hit = (mgmt_req.addr >= `NACF_MAP_BASE) &&
                  (map_off < 16'(MAP_BYTES));
   wire ctrl_write_event = mgmt_req.write & csr_hit;
   wire ctrl_read_event = mgmt_req.read & csr_hit;
   wire map_wr = mgmt_req.write & map_hit;
   wire map_rd_ev = mgmt_req.read & map_hit;

   // ==================================================================
   // state decode
   wire st_idle = state_reg == NACF_IDLE;
   wire st_pend = state_reg == NACF_PENDING;
   wire st_prog = state_reg == NACF_IN_PROGRESS;
   wire st_done = state_reg == NACF_COMPLETE;

   // ==================================================================
   // operation selection
   wire ext_all = ext_reg == `NACF_EXT_ALL;
   wire is_commit = cmd_reg == `NACF_CMD_COMMIT;
   // commit never walks the fixed identification or vendor areas
   wire [AW-1:0] first_idx = is_commit ?
      AW'(`NACF_CUST_FIRST) : '0;
   wire [AW-1:0] last_idx = is_commit ?
      AW'(`NACF_CUST_LAST) : AW'(MAP_BYTES - 1);

   // ==================================================================
   // storage arbitration
   wire store_want = st_pend | st_prog;
   logic store_gnt;

   nacf_store_arb u_arb (
      .ref_clk(ref_clk),
      .reset(reset),
      .mon_req(mon_req),
      .mon_gnt(mon_gnt),
      .map_req(store_want),
      .map_gnt(store_gnt)
   );

   // ==================================================================
   // transfer engine
   wire rsp_take = st_prog & req_reg.valid & store_rsp.ack;
   wire last_byte = idx_reg == last_idx;
   // vendor codes are not implemented here and end as failed
   wire op_done = st_prog &
      (!ext_all | (rsp_take & (store_rsp.err | last_byte)));
   wire op_fail = !ext_all | store_rsp.err;
   wire issue = st_prog & ext_all & !req_reg.valid;
   // a whole-map load without a storage error overwrites every volatile byte, committed or not
   wire load_wr = rsp_take & !req_reg.write & !store_rsp.err;
   logic [7:0] map_rd;
   logic [7:0] eng_rd;

   nacf_map_ram #(
      .DEPTH(MAP_BYTES),
      .AW(AW)
   ) u_ram (
      .ref_clk(ref_clk),
      .host_we(map_wr),
      .host_addr(map_off[AW-1:0]),
      .host_wdata(mgmt_req.wdata[7:0]),
      .host_rdata(map_rd),
      .eng_we(load_wr),
      .eng_addr(idx_reg),
      .eng_wdata(store_rsp.rdata),
      .eng_rdata(eng_rd)
   );

   always_comb
   begin
      req_next = req_reg;
      if (issue)
      begin
         req_next.valid = 1'b1;
         req_next.write = cmd_reg;
         req_next.addr = 16'(idx_reg);
         req_next.wdata = eng_rd;
      end
      else if (rsp_take)
      begin
         req_next.valid = 1'b0;
      end
   end

   // ==================================================================
   // access state machine
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         NACF_IDLE:
         begin
            if (ctrl_write_event)
            begin
               state_next = NACF_PENDING;
            end
         end
         NACF_PENDING:
         begin
            if (store_gnt)
            begin
               state_next = NACF_IN_PROGRESS;
            end
         end
         NACF_IN_PROGRESS:
         begin
            if (op_done)
            begin
               state_next = NACF_COMPLETE;
            end
         end
         NACF_COMPLETE:
         begin
            if (ctrl_read_event)
            begin
               state_next = NACF_IDLE;
            end
         end
         default:
         begin
            state_next = NACF_IDLE;
         end
      endcase
   end

   // ==================================================================
   // control/status view
   wire [1:0] status = st_idle ? `NACF_ST_IDLE :
                       !st_done ? `NACF_ST_BUSY :
                       fail_reg ? `NACF_ST_FAIL : `NACF_ST_OK;
   wire [15:0] csr_val = {vend_reg, 3'b000, cmd_reg, 1'b0,
                          status, ext_reg};

   always_comb
   begin
      rdata_next = rdata_reg;
      if (ctrl_read_event)
      begin
         rdata_next = csr_val;
      end
      else if (map_rd_ev)
      begin
         rdata_next = {8'h00, map_rd};
      end
      else if (mgmt_req.read)
      begin
         rdata_next = 16'h0000;
      end
   end

   // ==================================================================
   // registers
   // reset enters the queue with a whole-map load, so power-up reloads
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= AUTO_LOAD ? NACF_PENDING : NACF_IDLE;
         cmd_reg <= `NACF_CMD_LOAD;
         ext_reg <= `NACF_EXT_ALL;
         vend_reg <= `NACF_VEND_RESET;
         fail_reg <= 1'b0;
         idx_reg <= '0;
         req_reg <= '0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         req_reg <= req_next;
         rdata_reg <= rdata_next;
         if (st_idle && ctrl_write_event)
         begin
            vend_reg <= mgmt_req.wdata[`NACF_VEND_HI:`NACF_VEND_LO];
            cmd_reg <= mgmt_req.wdata[`NACF_CMD_BIT];
            ext_reg <= mgmt_req.wdata[`NACF_EXT_HI:`NACF_EXT_LO];
            fail_reg <= 1'b0;
         end
         if (st_pend)
         begin
            idx_reg <= first_idx;
         end
         else if (rsp_take && !last_byte)
         begin
            idx_reg <= idx_reg + AW'(1);
         end
         if (op_done)
         begin
            fail_reg <= op_fail;
         end
      end
   end

   assign mgmt_rdata = rdata_reg;
   assign store_req = req_reg;

   // ==================================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   chk_csr_fixed_bits: assert property (
      $past(ctrl_read_event) |->
         (mgmt_rdata[8:6] == 3'b000) && (mgmt_rdata[4] == 1'b0))
      else $error("reserved control bits read nonzero");

   chk_cmd_held: assert property (
      !st_idle && !$past(st_idle) |->
         $stable(cmd_reg) && $stable(ext_reg))
      else $error("command changed while active");

   chk_idle_write_start: assert property (
      st_idle && ctrl_write_event |=>
         st_pend && cmd_reg == $past(mgmt_req.wdata[5]) &&
         ext_reg == $past(mgmt_req.wdata[1:0]))
      else $error("idle write did not queue command");

   chk_busy_write_ignored: assert property (
      !st_idle && ctrl_write_event |=>
         $stable(vend_reg) && $stable(cmd_reg) && $stable(ext_reg))
      else $error("write accepted while busy");

   chk_busy_status: assert property (
      (st_pend || st_prog) && ctrl_read_event |=>
         mgmt_rdata[3:2] == 2'b10)
      else $error("busy status not reported");

   chk_pending_wait: assert property (
      st_pend && !store_gnt |=> st_pend)
      else $error("queued command ran without grant");

   chk_grant_advance: assert property (
      st_pend && store_gnt |=> st_prog ##1 (req_reg.valid || st_done))
      else $error("granted command did not start");

   chk_finish_read: assert property (
      st_done && ctrl_read_event |=>
         st_idle && mgmt_rdata[3:2] == (fail_reg ? 2'b11 : 2'b01)
         ##1 status == 2'b00)
      else $error("finished read did not return to idle");

   chk_other_read: assert property (
      !st_done && ctrl_read_event && !ctrl_write_event && !st_pend &&
      !st_prog |=> state_reg == $past(state_reg))
      else $error("read changed state");

   chk_commit_region: assert property (
      store_req.valid && store_req.write |->
         store_req.addr >= `NACF_CUST_FIRST &&
         store_req.addr <= `NACF_CUST_LAST)
      else $error("commit outside customer area");

   chk_vendor_fails: assert property (
      st_prog && !ext_all |=> st_done && status == 2'b11)
      else $error("vendor code did not end failed");

   chk_store_error: assert property (
      rsp_take && store_rsp.err |=> st_done && status == 2'b11)
      else $error("storage error not reported");

   chk_load_direction: assert property (
      store_req.valid && !is_commit |-> !store_req.write)
      else $error("load issued a storage write");

   cov_commit_ok: cover property (
      st_prog && is_commit ##[1:1000] st_done && !fail_reg);

   cov_load_ok: cover property (
      st_prog && !is_commit ##[1:1000] st_done && !fail_reg);

   cov_queued_wait: cover property (
      st_pend && mon_gnt ##1 st_pend ##[1:50] st_prog);

   cov_busy_write: cover property (
      st_prog && ctrl_write_event);

endmodule : nacf_top

// ==== verif/nacf_store_model.sv ====
// storage partner: a byte store that answers each transfer after a delay
// assumes the device holds valid and its fields until ack
`timescale 1ns/1ps

module nacf_store_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // transfer port
   input wire nacf_pkg::nacf_store_req_t store_req,
   output nacf_pkg::nacf_store_rsp_t store_rsp,
   // behaviour control
   input wire logic [3:0] delay,
   input wire logic fail
);
   import nacf_pkg::*;

   logic [7:0] mem [0:255];
   logic [3:0] wait_cnt;

   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i * 5 + 3);
   end

   // =================================================================
   // answer path
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         store_rsp <= '0;
         wait_cnt <= 4'h0;
      end
      else
      begin
         store_rsp.ack <= 1'b0;
         store_rsp.err <= 1'b0;
         // data is not held outside an ack, so it keeps changing
         store_rsp.rdata <= ~store_rsp.rdata;
         if (store_req.valid && !store_rsp.ack)
         begin
            if (wait_cnt < delay)
               wait_cnt <= wait_cnt + 4'h1;
            else
            begin
               wait_cnt <= 4'h0;
               store_rsp.ack <= 1'b1;
               store_rsp.err <= fail;
               store_rsp.rdata <= mem[store_req.addr[7:0]];
               if (store_req.write && !fail)
                  mem[store_req.addr[7:0]] <= store_req.wdata;
            end
         end
      end
   end

endmodule : nacf_store_model

// ==== verif/nacf_top_tb.sv ====
// self-checking bench for the persistent map access block
// assumes nacf_params.svh on the include path and the storage model
`timescale 1ns/1ps
`include "nacf_params.svh"

module nacf_top_tb;
   import nacf_pkg::*;

   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   nacf_mgmt_req_t mgmt_req = '0;
   logic [15:0] mgmt_rdata;
   nacf_store_req_t store_req;
   nacf_store_rsp_t store_rsp;
   logic mon_req = 1'b0;
   logic mon_gnt;
   logic [3:0] delay = 4'h0;
   logic fail = 1'b0;
   int failures = 0;
   int n_compared = 0;
   logic [15:0] rd;
   logic [6:0] vend;
   logic [7:0] shadow [0:255];
   logic [7:0] stored [0:255];

   always #10 ref_clk = ~ref_clk;

   nacf_top #(.MAP_BYTES(256), .AW(8), .AUTO_LOAD(1'b1)) dut_u (
      .ref_clk(ref_clk), .reset(reset), .mgmt_req(mgmt_req),
      .mgmt_rdata(mgmt_rdata), .store_req(store_req),
      .store_rsp(store_rsp), .mon_req(mon_req), .mon_gnt(mon_gnt));

   nacf_store_model store_u (
      .ref_clk(ref_clk), .reset(reset), .store_req(store_req),
      .store_rsp(store_rsp), .delay(delay), .fail(fail));

   // =================================================================
   // helpers
   function automatic logic [7:0] seed_byte(input int i);
      return 8'((i * 5) + 3);
   endfunction : seed_byte

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   task automatic mgmt_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      mgmt_req.write = 1'b1;
      mgmt_req.addr = a;
      mgmt_req.wdata = d;
      @(negedge ref_clk);
      mgmt_req.write = 1'b0;
   endtask : mgmt_write

   task automatic mgmt_read(input logic [15:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      mgmt_req.read = 1'b1;
      mgmt_req.addr = a;
      @(negedge ref_clk);
      mgmt_req.read = 1'b0;
      d = mgmt_rdata;
   endtask : mgmt_read

   // reads while busy leave the state alone, so polling is safe
   task automatic poll(output logic [15:0] d);
      for (int k = 0; k < 4000; k++)
      begin
         mgmt_read(`NACF_CSR_ADDR, d);
         if (d[3:2] !== `NACF_ST_BUSY)
            break;
      end
   endtask : poll

   task automatic finish_cmd(input logic [1:0] st);
      poll(rd);
      check({14'h0000, rd[3:2]}, {14'h0000, st});
      mgmt_read(`NACF_CSR_ADDR, rd);
      check({14'h0000, rd[3:2]}, 16'h0000);
   endtask : finish_cmd

   task automatic check_map;
      for (int i = 0; i < 256; i++)
      begin
         mgmt_read(`NACF_MAP_BASE + 16'(i), rd);
         check(rd, {8'h00, shadow[i]});
      end
   endtask : check_map

   task automatic scribble(input int n);
      int i;
      for (int k = 0; k < n; k++)
      begin
         i = (k < 2) ? ((k == 0) ? 'h77 : 'hA6) : int'($urandom % 256);
         shadow[i] = 8'($urandom);
         mgmt_write(`NACF_MAP_BASE + 16'(i), {8'($urandom), shadow[i]});
      end
   endtask : scribble

   // =================================================================
   // main sequence
   initial
   begin
      void'($urandom(32'h0000_02d2));
      for (int i = 0; i < 256; i++)
      begin
         shadow[i] = seed_byte(i);
         stored[i] = seed_byte(i);
      end
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      finish_cmd(`NACF_ST_OK);
      check_map;
      mgmt_read(16'h0001, rd);
      check(rd, 16'h0000);
      // vendor codes with reserved bits forced high
      for (int c = 0; c < 6; c++)
      begin
         vend = 7'($urandom);
         mgmt_write(`NACF_CSR_ADDR, {vend, 3'h7, 1'(c / 3), 3'h7,
            2'(c % 3)});
         poll(rd);
         check(rd, {vend, 3'h0, 1'(c / 3), 3'h3, 2'(c % 3)});
         mgmt_read(`NACF_CSR_ADDR, rd);
         check({14'h0000, rd[3:2]}, 16'h0000);
      end
      scribble(40);
      check_map;
      for (int i = 0; i < 256; i++)
         check({8'h00, store_u.mem[i]}, {8'h00, stored[i]});
      // commit on slow storage, with a write that must be ignored
      delay = 4'($urandom_range(7, 1));
      mgmt_write(`NACF_CSR_ADDR, 16'h0023);
      mgmt_read(`NACF_CSR_ADDR, rd);
      check({10'h000, rd[5:0]}, 16'h002B);
      mgmt_write(`NACF_CSR_ADDR, 16'h0000);
      mgmt_read(`NACF_CSR_ADDR, rd);
      check({10'h000, rd[5:0]}, 16'h002B);
      finish_cmd(`NACF_ST_OK);
      for (int i = 'h77; i <= 'hA6; i++)
         stored[i] = shadow[i];
      for (int i = 0; i < 256; i++)
         check({8'h00, store_u.mem[i]}, {8'h00, stored[i]});
      // uncommitted changes are dropped by a load, even with the
      // monitor holding the storage when the load is issued
      delay = 4'h0;
      scribble(20);
      mon_req = 1'b1;
      @(negedge ref_clk);
      check({15'h0000, mon_gnt}, 16'h0001);
      mgmt_write(`NACF_CSR_ADDR, 16'h0003);
      for (int k = 0; k < 10; k++)
      begin
         mgmt_read(`NACF_CSR_ADDR, rd);
         check({14'h0000, rd[3:2]}, 16'h0002);
         check({15'h0000, store_req.valid}, 16'h0000);
      end
      mon_req = 1'b0;
      finish_cmd(`NACF_ST_OK);
      for (int i = 0; i < 256; i++)
         shadow[i] = stored[i];
      check_map;
      // storage error ends the command as failed
      fail = 1'b1;
      mgmt_write(`NACF_CSR_ADDR, 16'h0023);
      finish_cmd(`NACF_ST_FAIL);
      fail = 1'b0;
      // second reset in mid-run reloads the whole map
      scribble(10);
      reset = 1'b1;
      @(negedge ref_clk);
      reset = 1'b0;
      for (int i = 0; i < 256; i++)
         shadow[i] = stored[i];
      finish_cmd(`NACF_ST_OK);
      check_map;
      final_report;
   end

   // =================================================================
   // watchdog: the run needs about 5000 cycles, this allows 20000
   initial
   begin
      #400us;
      failures++;
      final_report;
   end

endmodule : nacf_top_tb
